// file: core/gpio_axil_slave.sv
/*
 * AXI4-Lite slave front end: takes one write and one read at a time and
 * turns them into single-cycle register strobes.
 * Assumes the register file answers reads and errors combinationally.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_defs.svh"

module gpio_axil_slave (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [31:0] awaddr, // Write address
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Write byte strobes
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output logic [1:0] bresp, // Write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic [31:0] araddr, // Read address
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read response
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    output logic wr_en, // Register write strobe
    output logic [31:0] wr_addr, // Register write address
    output logic [31:0] wr_data, // Register write data
    output logic [3:0] wr_strb, // Register write byte lanes
    input wire logic wr_err, // Write address unmapped
    output logic rd_en, // Register read strobe
    output logic [31:0] rd_addr, // Register read address
    input wire logic [31:0] rd_data, // Register read data
    input wire logic rd_err // Read address unmapped
);

    gpio_port_pkg::slave_state_type st_ff;
    gpio_port_pkg::slave_state_type nxt_st;

    assign awready = !st_ff.aw_got && st_ff.wr_state == gpio_port_pkg::WR_IDLE;
    assign wready = !st_ff.w_got && st_ff.wr_state == gpio_port_pkg::WR_IDLE;
    assign bvalid = st_ff.wr_state == gpio_port_pkg::WR_RESP;
    assign bresp = st_ff.bresp;
    assign arready = st_ff.rd_state == gpio_port_pkg::RD_IDLE;
    assign rvalid = st_ff.rd_state == gpio_port_pkg::RD_DATA;
    assign rdata = st_ff.rdata;
    assign rresp = st_ff.rresp;
    assign wr_en = st_ff.aw_got && st_ff.w_got && st_ff.wr_state == gpio_port_pkg::WR_IDLE;
    assign wr_addr = st_ff.awaddr;
    assign wr_data = st_ff.wdata;
    assign wr_strb = st_ff.wstrb;
    assign rd_en = arvalid && arready;
    assign rd_addr = araddr;

    // ------------------------------------------------------------------
    // Channel handshakes
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (awvalid && awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = wdata;
            nxt_st.wstrb = wstrb;
        end
        case (st_ff.wr_state)
            gpio_port_pkg::WR_IDLE: begin
                if (wr_en) begin
                    nxt_st.aw_got = 1'b0;
                    nxt_st.w_got = 1'b0;
                    nxt_st.bresp = wr_err ? `RESP_SLVERR : `RESP_OKAY;
                    nxt_st.wr_state = gpio_port_pkg::WR_RESP;
                end
            end
            default: begin
                if (bready) begin
                    nxt_st.wr_state = gpio_port_pkg::WR_IDLE;
                end
            end
        endcase
        case (st_ff.rd_state)
            gpio_port_pkg::RD_IDLE: begin
                if (rd_en) begin
                    nxt_st.rdata = rd_data;
                    nxt_st.rresp = rd_err ? `RESP_SLVERR : `RESP_OKAY;
                    nxt_st.rd_state = gpio_port_pkg::RD_DATA;
                end
            end
            default: begin
                if (rready) begin
                    nxt_st.rd_state = gpio_port_pkg::RD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule : gpio_axil_slave
`default_nettype wire

// file: core/gpio_port2_port4.sv
/*
 * Port-2 data output / input registers, port-2 function and direction
 * registers, and the single-pin port-4 function, direction and pull-up
 * logic, behind an AXI4-Lite slave.
 * Assumes pad cells outside resolve pin levels from out/oe and apply
 * the pull-up enables; pin levels arrive asynchronously.
 */
// Local design decision: the AXI4-Lite interface to the registers.
// Contract
// (R1) Port-2 output bits drive GPIO-output pins; reset zero
// (R2) Port-2 output upper bits ignore writes
// (R3) Port-2 input reads live pin levels
// (R4) Port-2 input upper bits read zero
// (R5) Port-4 function register resets to 0x0015_5555
// (R6) Port-4 codes: GPIO, wait request, interrupt three
// (R7) Port-4 direction bit 26 enables pull-up
// (R8) Port-4 direction resets zero, pull-up off
// (R9) Port-4 direction bit 10 makes pin output
// (R10) Port-4 output enable only in GPIO mode
// (R11) Port-2 direction low bits are output enables
// (R12) Port-2 enables apply only in GPIO mode
// (R13) Non-output pins keep stored bit, never drive
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_defs.svh"

module gpio_port2_port4 (
    input wire logic aclk, // System clock, 20 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [31:0] awaddr, // Write address
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Write byte strobes
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output logic [1:0] bresp, // Write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic [31:0] araddr, // Read address
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read response
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    input wire logic [9:0] second_port_pin_in, // Port-2 pin levels
    output logic [9:0] second_port_pin_out, // Port-2 pin drive values
    output logic [9:0] second_port_pin_oe, // Port-2 pin drive enables
    output logic [9:0] second_port_pullup_enable, // Port-2 pull-ups
    output logic [19:0] second_port_pin_functions, // Port-2 function codes
    input wire logic fourth_port_general_pin_in, // Port-4 pin level
    output logic fourth_port_general_pin_out, // Port-4 pin drive value
    output logic fourth_port_general_pin_oe, // Port-4 pin drive enable
    input wire logic fourth_port_out_value, // Port-4 data output bit
    output logic fourth_port_in_level, // Port-4 synchronised level
    output logic fourth_port_pullup_enable, // Port-4 pull-up
    output logic bus_wait_request_in, // Wait request to bus, low active
    output logic external_interrupt_three_n // Interrupt three, low active
);

    gpio_port_pkg::port_state_type st_ff;
    gpio_port_pkg::port_state_type nxt_st;

    logic wr_en;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic rd_en;
    logic [31:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    logic [31:0] lane_mask;
    logic [31:0] old_word;
    logic [31:0] new_word;

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    gpio_axil_slave i_gpio_axil_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // ------------------------------------------------------------------
    // Register images and byte-lane merge
    // ------------------------------------------------------------------
    function automatic logic [31:0] image(input gpio_port_pkg::port_state_type s,
                                          input logic [31:0] addr);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (addr == `P2_FUNC_ADDR) begin
            w[`P2_FUNC_MSB:0] = s.p2_func;
        end else if (addr == `P2_DIR_ADDR) begin
            w[`P2_PUP_MSB:`P2_PUP_LSB] = s.p2_pup;
            w[`P2_BITS_MSB:0] = s.p2_oe;
        end else if (addr == `P2_OUT_ADDR) begin
            w[`P2_BITS_MSB:0] = s.p2_out;
        end else if (addr == `P2_IN_ADDR) begin
            w[`P2_BITS_MSB:0] = s.p2_sync2; // R3 R4
        end else if (addr == `P4_FUNC_ADDR) begin
            w = `P4_FUNC_RESET & `P4_FUNC_RSVD_MASK;
            w[`P4_FUNC_MSB:`P4_FUNC_LSB] = s.p4_func;
        end else if (addr == `P4_DIR_ADDR) begin
            w[`P4_PUP_BIT] = s.p4_pup;
            w[`P4_OE_BIT] = s.p4_oe;
        end
        return w;
    endfunction : image

    function automatic logic mapped(input logic [31:0] addr);
        return addr == `P2_FUNC_ADDR || addr == `P2_DIR_ADDR || addr == `P2_OUT_ADDR ||
               addr == `P2_IN_ADDR || addr == `P4_FUNC_ADDR || addr == `P4_DIR_ADDR;
    endfunction : mapped

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign lane_mask[8*g+7:8*g] = {8{wr_strb[g]}};
        end
    endgenerate

    assign old_word = image(st_ff, wr_addr);
    assign new_word = (old_word & ~lane_mask) | (wr_data & lane_mask);
    assign wr_err = !mapped(wr_addr);
    assign rd_err = !mapped(rd_addr);
    assign rd_data = image(st_ff, rd_addr);

    // ------------------------------------------------------------------
    // Next state: synchronisers and register writes
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.p2_sync1 = second_port_pin_in;
        nxt_st.p2_sync2 = st_ff.p2_sync1;
        nxt_st.p4_sync1 = fourth_port_general_pin_in;
        nxt_st.p4_sync2 = st_ff.p4_sync1;
        if (wr_en) begin
            if (wr_addr == `P2_FUNC_ADDR) begin
                nxt_st.p2_func = new_word[`P2_FUNC_MSB:0];
            end else if (wr_addr == `P2_DIR_ADDR) begin
                nxt_st.p2_pup = new_word[`P2_PUP_MSB:`P2_PUP_LSB];
                nxt_st.p2_oe = new_word[`P2_BITS_MSB:0]; // R11
            end else if (wr_addr == `P2_OUT_ADDR) begin
                nxt_st.p2_out = new_word[`P2_BITS_MSB:0]; // R2
            end else if (wr_addr == `P4_FUNC_ADDR) begin
                nxt_st.p4_func = gpio_port_pkg::pin_func_type'(
                    new_word[`P4_FUNC_MSB:`P4_FUNC_LSB]);
            end else if (wr_addr == `P4_DIR_ADDR) begin
                nxt_st.p4_pup = new_word[`P4_PUP_BIT]; // R7
                nxt_st.p4_oe = new_word[`P4_OE_BIT]; // R9
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0; // R1 R8
            st_ff.p4_func <= gpio_port_pkg::pin_func_type'(
                2'(`P4_FUNC_RESET >> `P4_FUNC_LSB)); // R5
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Port-2 pins
    // ------------------------------------------------------------------
    generate
        for (g = 0; g < `P2_PINS; g++) begin : g_p2_pin
            assign second_port_pin_out[g] = st_ff.p2_out[g]; // R1
            assign second_port_pin_oe[g] = st_ff.p2_oe[g] &&
                st_ff.p2_func[2*g+1:2*g] == gpio_port_pkg::FUNC_GPIO; // R12 R13
        end
    endgenerate

    assign second_port_pullup_enable = st_ff.p2_pup;
    assign second_port_pin_functions = st_ff.p2_func;

    // ------------------------------------------------------------------
    // Port-4 pin
    // ------------------------------------------------------------------
    assign fourth_port_general_pin_out = fourth_port_out_value;
    assign fourth_port_general_pin_oe = st_ff.p4_oe &&
        st_ff.p4_func == gpio_port_pkg::FUNC_GPIO; // R10 R13
    assign fourth_port_pullup_enable = st_ff.p4_pup; // R7
    assign fourth_port_in_level = st_ff.p4_sync2;
    assign bus_wait_request_in = st_ff.p4_func == gpio_port_pkg::FUNC_ALT1 ?
        st_ff.p4_sync2 : 1'b1; // R6
    assign external_interrupt_three_n = st_ff.p4_func == gpio_port_pkg::FUNC_ALT2 ?
        st_ff.p4_sync2 : 1'b1; // R6

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_p2_out_write: assert property ( // R1
        wr_en && wr_addr == `P2_OUT_ADDR && wr_strb == 4'hF
        |=> second_port_pin_out == $past(wr_data[`P2_BITS_MSB:0]))
        else $error("port-2 output bits not written");

    chk_p2_out_upper: assert property ( // R2
        wr_en && wr_addr == `P2_OUT_ADDR |=> image(st_ff, `P2_OUT_ADDR) >> `P2_PINS == 32'h0)
        else $error("port-2 output upper bits stored");

    chk_p2_in_live: assert property ( // R3
        rd_en && rd_addr == `P2_IN_ADDR
        |-> rd_data[`P2_BITS_MSB:0] == $past(second_port_pin_in, 2))
        else $error("port-2 input read not live level");

    chk_p2_in_upper: assert property ( // R4
        rd_en && rd_addr == `P2_IN_ADDR |-> rd_data >> `P2_PINS == 32'h0)
        else $error("port-2 input upper bits nonzero");

    chk_p4_reset_val: assert property ( // R5
        $rose(aresetn) |-> image(st_ff, `P4_FUNC_ADDR) == `P4_FUNC_RESET)
        else $error("port-4 function reset value wrong");

    chk_p4_func_route: assert property ( // R6
        st_ff.p4_func == gpio_port_pkg::FUNC_ALT2
        |-> external_interrupt_three_n == fourth_port_in_level && bus_wait_request_in)
        else $error("port-4 interrupt routing wrong");

    chk_p4_pullup_bit: assert property ( // R7
        wr_en && wr_addr == `P4_DIR_ADDR && wr_strb[3]
        |=> fourth_port_pullup_enable == $past(wr_data[`P4_PUP_BIT]))
        else $error("port-4 pull-up bit not applied");

    chk_p4_dir_reset: assert property ( // R8
        $rose(aresetn) |-> !fourth_port_pullup_enable && image(st_ff, `P4_DIR_ADDR) == 32'h0)
        else $error("port-4 direction not clear after reset");

    chk_p4_oe_gpio: assert property ( // R9
        st_ff.p4_func == gpio_port_pkg::FUNC_GPIO && wr_en && wr_addr == `P4_DIR_ADDR &&
        wr_strb[1] |=> fourth_port_general_pin_oe == $past(wr_data[`P4_OE_BIT]))
        else $error("port-4 output enable not applied");

    chk_p4_oe_alt: assert property ( // R10
        st_ff.p4_func != gpio_port_pkg::FUNC_GPIO |-> !fourth_port_general_pin_oe)
        else $error("port-4 driven outside GPIO mode");

    chk_p2_oe_map: assert property ( // R11
        st_ff.p2_func == 20'h0 && wr_en && wr_addr == `P2_DIR_ADDR && wr_strb[1:0] == 2'h3
        |=> second_port_pin_oe == $past(wr_data[`P2_BITS_MSB:0]))
        else $error("port-2 output enables not applied");

    chk_p2_oe_alt: assert property ( // R12
        (second_port_pin_oe & ~st_ff.p2_oe) == 10'h0 &&
        !(second_port_pin_oe[0] && st_ff.p2_func[1:0] != 2'h0))
        else $error("port-2 driven outside GPIO mode");

    chk_p2_keep_bit: assert property ( // R13
        !wr_en ##1 !second_port_pin_oe[9] |-> $stable(second_port_pin_out))
        else $error("port-2 stored bit changed without write");

    chk_p2_out_hold: assert property ( // R13
        !(wr_en && wr_addr == `P2_OUT_ADDR) |=> $stable(second_port_pin_out))
        else $error("port-2 output bits changed without write");

    chk_p2_oe_off: assert property ( // R11
        wr_en && wr_addr == `P2_DIR_ADDR && wr_strb[1:0] == 2'h3
        |=> (second_port_pin_oe & ~$past(wr_data[`P2_BITS_MSB:0])) == 10'h0)
        else $error("port-2 input-mode pin driven");

    chk_p4_wait_route: assert property ( // R6
        st_ff.p4_func == gpio_port_pkg::FUNC_ALT1
        |-> bus_wait_request_in == fourth_port_in_level && external_interrupt_three_n)
        else $error("port-4 wait request routing wrong");

    chk_p4_alt_idle: assert property ( // R6
        st_ff.p4_func inside {gpio_port_pkg::FUNC_GPIO, gpio_port_pkg::FUNC_RSVD}
        |-> bus_wait_request_in && external_interrupt_three_n)
        else $error("port-4 alternate inputs not idle");

    chk_pins_reset: assert property ( // R1
        $rose(aresetn) |-> second_port_pin_out == 10'h0 && second_port_pin_oe == 10'h0 &&
        !fourth_port_general_pin_oe && !fourth_port_pullup_enable)
        else $error("pin drive not clear after reset");

endmodule : gpio_port2_port4
`default_nettype wire

// file: core/gpio_port_defs.svh
/*
 * Register offsets, field positions, reset values and response codes
 * for the port-2 data / port-4 configuration GPIO block.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define P2_FUNC_ADDR 32'hFFF8_3020
`define P2_DIR_ADDR 32'hFFF8_3024
`define P2_OUT_ADDR 32'hFFF8_3028
`define P2_IN_ADDR 32'hFFF8_302C
`define P4_FUNC_ADDR 32'hFFF8_3040
`define P4_DIR_ADDR 32'hFFF8_3044

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define P2_PINS 10
`define P2_BITS_MSB 9
`define P2_FUNC_MSB 19
`define P2_PUP_LSB 16
`define P2_PUP_MSB 25
`define P4_FUNC_LSB 20
`define P4_FUNC_MSB 21
`define P4_OE_BIT 10
`define P4_PUP_BIT 26

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define P2_FUNC_RESET 32'h0000_0000
`define P2_DIR_RESET 32'h0000_0000
`define P2_OUT_RESET 32'h0000_0000
`define P4_FUNC_RESET 32'h0015_5555
`define P4_DIR_RESET 32'h0000_0000
`define P4_FUNC_RSVD_MASK 32'hFFCF_FFFF

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: core/gpio_port_pkg.sv
/*
 * Types shared by the GPIO block and its bus slave.
 * Assumes the constants of gpio_port_defs.svh.
 */
`default_nettype none
package gpio_port_pkg;

    // ------------------------------------------------------------------
    // Pin function codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FUNC_GPIO = 2'h0,
        FUNC_ALT1 = 2'h1,
        FUNC_ALT2 = 2'h2,
        FUNC_RSVD = 2'h3
    } pin_func_type;

    // ------------------------------------------------------------------
    // Bus slave states
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        WR_IDLE = 1'h0,
        WR_RESP = 1'h1
    } wr_state_type;

    typedef enum logic [0:0] {
        RD_IDLE = 1'h0,
        RD_DATA = 1'h1
    } rd_state_type;

    typedef struct packed {
        wr_state_type wr_state;
        rd_state_type rd_state;
        logic aw_got;
        logic w_got;
        logic [31:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } slave_state_type;

    // ------------------------------------------------------------------
    // Port state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [9:0] p2_out;
        logic [19:0] p2_func;
        logic [9:0] p2_oe;
        logic [9:0] p2_pup;
        pin_func_type p4_func;
        logic p4_oe;
        logic p4_pup;
        logic [9:0] p2_sync1;
        logic [9:0] p2_sync2;
        logic p4_sync1;
        logic p4_sync2;
    } port_state_type;

endpackage : gpio_port_pkg
`default_nettype wire

// file: tb/gpio_pin_model.sv
/*
 * Pad model for both ports: resolves each pin from the block's drive
 * and an outside driver. Assumes the outside driver always drives.
 */
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_model (
    input wire logic [9:0] p2_out, // Port-2 drive values
    input wire logic [9:0] p2_oe, // Port-2 drive enables
    input wire logic [9:0] p2_ext, // Outside drive, port 2
    input wire logic p4_out, // Port-4 drive value
    input wire logic p4_oe, // Port-4 drive enable
    input wire logic p4_ext, // Outside drive, port 4
    output logic [9:0] p2_level, // Port-2 pin levels
    output logic p4_level // Port-4 pin level
);
    // Enabled pad wins over outside driver
    assign p2_level = (p2_oe & p2_out) | (~p2_oe & p2_ext);
    assign p4_level = p4_oe ? p4_out : p4_ext;
endmodule : gpio_pin_model

`default_nettype wire

// file: tb/test_gpio_port2_port4.sv
/*
 * Self-checking bench for gpio_port2_port4 over AXI4-Lite.
 * Assumes gpio_port_defs.svh and gpio_pin_model.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_defs.svh"
`define CHK(n, e, s) begin n_tests++; if ((e) !== (s)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end

module test_gpio_port2_port4;
    logic aclk = 0, aresetn = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, d, v;
    logic awvalid = 0, wvalid = 0, arvalid = 0, bready = 1, rready = 1;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, p4_oe, p4_pin, p4_drv, p4_lvl;
    logic [1:0] bresp, rresp, r, c;
    logic [9:0] p2_pin, p2_drv, p2_oe, p2_pup, oe, pup, eoe;
    logic [9:0] p2_ext = 0;
    logic [19:0] p2_fn, fn;
    logic p4_ext = 0, p4_val = 0, p4_pup, wait_n, irq_n, oe4, pu, lv;
    int n_mismatch = 0, n_tests = 0;

    always #25 aclk = ~aclk;

    gpio_port2_port4 i_gpio_port2_port4 (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .second_port_pin_in(p2_pin), .second_port_pin_out(p2_drv),
        .second_port_pin_oe(p2_oe), .second_port_pullup_enable(p2_pup),
        .second_port_pin_functions(p2_fn), .fourth_port_general_pin_in(p4_pin),
        .fourth_port_general_pin_out(p4_drv), .fourth_port_general_pin_oe(p4_oe),
        .fourth_port_out_value(p4_val), .fourth_port_in_level(p4_lvl),
        .fourth_port_pullup_enable(p4_pup), .bus_wait_request_in(wait_n),
        .external_interrupt_three_n(irq_n));

    gpio_pin_model i_gpio_pin_model (.p2_out(p2_drv), .p2_oe(p2_oe), .p2_ext(p2_ext),
        .p4_out(p4_drv), .p4_oe(p4_oe), .p4_ext(p4_ext), .p2_level(p2_pin),
        .p4_level(p4_pin));

    // ------------------------------------------------------------------
    // Bus tasks: answers sampled at the rising edge
    // ------------------------------------------------------------------
    task automatic axw(input logic [31:0] a, input logic [31:0] x);
        logic ga, gw;
        ga = 0;
        gw = 0;
        awaddr <= a;
        wdata <= x;
        awvalid <= 1;
        wvalid <= 1;
        while (!(ga && gw)) begin
            @(posedge aclk);
            ga = ga | awready;
            gw = gw | wready;
            if (ga) awvalid <= 0;
            if (gw) wvalid <= 0;
        end
        do @(posedge aclk); while (!bvalid);
        r = bresp;
    endtask : axw

    task automatic axr(input logic [31:0] a);
        araddr <= a;
        arvalid <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
    endtask : axr

    function automatic logic [9:0] gpio_mask(input logic [19:0] f);
        for (int i = 0; i < 10; i++) gpio_mask[i] = (f[2*i+:2] == 2'h0);
    endfunction : gpio_mask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up

    initial begin
        #1000000;
        n_mismatch++;
        wrap_up();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h1D4A7C72));
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        `CHK("p4 pullup reset", 1'b0, p4_pup)
        `CHK("p2 oe reset", 10'h000, p2_oe)
        axr(`P2_OUT_ADDR);
        `CHK("p2 out reset", 32'h0000_0000, d)
        axr(`P4_FUNC_ADDR);
        `CHK("p4 func reset", 32'h0015_5555, d)
        axr(`P4_DIR_ADDR);
        `CHK("p4 dir reset", 32'h0000_0000, d)
        axr(32'hFFF8_3030);
        `CHK("bad read resp", `RESP_SLVERR, r)
        axw(32'hFFF8_3030, 32'hFFFF_FFFF);
        `CHK("bad write resp", `RESP_SLVERR, r)
        for (int k = 0; k < 24; k++) begin
            fn = (k == 0) ? 20'h00000 : 20'($urandom);
            oe = (k == 0) ? 10'h3FF : 10'($urandom);
            pup = 10'($urandom);
            v = (k < 2) ? 32'hFFFF_FFFF : $urandom;
            eoe = oe & gpio_mask(fn);
            axw(`P2_FUNC_ADDR, {12'h000, fn});
            axw(`P2_DIR_ADDR, {6'h00, pup, 6'h00, oe});
            axw(`P2_OUT_ADDR, v);
            p2_ext <= 10'($urandom);
            repeat (4) @(posedge aclk);
            `CHK("p2 functions", fn, p2_fn)
            `CHK("p2 oe", eoe, p2_oe)
            `CHK("p2 pullups", pup, p2_pup)
            `CHK("p2 drive", v[9:0], p2_drv)
            axr(`P2_OUT_ADDR);
            `CHK("p2 out read", {22'h000000, v[9:0]}, d)
            axr(`P2_IN_ADDR);
            `CHK("p2 in read", {22'h000000, (eoe & v[9:0]) | (~eoe & p2_ext)}, d)
        end
        wstrb <= 4'h2;
        axw(`P2_OUT_ADDR, 32'h0000_0000);
        wstrb <= 4'hF;
        axr(`P2_OUT_ADDR);
        `CHK("p2 out lane", {22'h000000, 2'h0, v[7:0]}, d)
        for (int k = 0; k < 16; k++) begin
            c = k[1:0];
            oe4 = k[2];
            pu = k[3];
            axw(`P4_FUNC_ADDR, {10'h000, c, 20'h00000} | ($urandom & `P4_FUNC_RSVD_MASK));
            axw(`P4_DIR_ADDR, {5'h00, pu, 15'h0000, oe4, 10'h000});
            p4_ext <= 1'($urandom);
            p4_val <= 1'($urandom);
            repeat (4) @(posedge aclk);
            lv = (c == 2'h0 && oe4) ? p4_val : p4_ext;
            `CHK("p4 oe", c == 2'h0 && oe4, p4_oe)
            `CHK("p4 pullup", pu, p4_pup)
            `CHK("p4 level", lv, p4_lvl)
            `CHK("p4 drive", p4_val, p4_drv)
            `CHK("wait request", (c == 2'h1) ? lv : 1'b1, wait_n)
            `CHK("interrupt three", (c == 2'h2) ? lv : 1'b1, irq_n)
            axr(`P4_FUNC_ADDR);
            `CHK("p4 func read", 32'h0005_5555 | {10'h000, c, 20'h00000}, d)
        end
        wrap_up();
    end
endmodule : test_gpio_port2_port4

`default_nettype wire
